// ### src/spiovr_pkg.sv
/*
  Shared constants for the SPI port with overrun halt: register offsets,
  control fields, status bits and timing figures.
  Assumes a 125 MHz system clock on both ends and APB on the host side.
*/
// Function
// - Master, short word, unread data: overrun halts.
// - Clearing overrun alone never restarts shifting.
// - Resume by clearing then setting port enable.
// - Sixteen-bit words never halt on overrun.
// - Master always captures input bits, idle ones.
// - Slave bit counter never cleared between words.
// - External master gives exact word clock edges.
// - Slave phase 0 loses word held in transmit buffer.
// - Double-buffered writes may load twice, lose word.
// - Overrun leaves residual upper bits in shifter.
// - Slave phase 0: toggle enable after full.
// - Or remote master drops select before edge.
// - Transmit-only software reads every received word.
package spiovr_pkg;
  localparam int unsigned DATA_W = 16;
  // APB register offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] TXD_OFS = 8'h08;
  localparam logic [7:0] RXD_OFS = 8'h0c;
  localparam logic [7:0] IMSK_OFS = 8'h10;
  // Control fields
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_MST_BIT = 1;
  localparam int unsigned CTRL_CLOCK_PHASE_SELECT_BIT = 2;
  localparam int unsigned CTRL_LEN_LSB = 4;
  localparam int unsigned CTRL_DIV_LSB = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0f00;
  // Status bits
  localparam int unsigned ST_FULL_BIT = 0;
  localparam int unsigned ST_OVR_BIT = 1;
  localparam int unsigned ST_TXE_BIT = 2;
  localparam int unsigned ST_HALT_BIT = 3;
  localparam logic [3:0] EVT_RST = 4'h0;
  // Serial clock: half period in system clocks, least value
  localparam int unsigned SCK_HALF_MIN_NS = 16;
  localparam int unsigned SYS_PERIOD_NS = 8;
  localparam int unsigned SCK_HALF_MIN_CYC = (SCK_HALF_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
endpackage

// ### src/spiovr_link_if.sv
/*
  Serial link between the SPI port and its far-end device.
  Assumes both ends run on clk_sys_i and the bench joins the modports.
*/
`timescale 1ns/100ps
interface spiovr_link_if;
  logic sck;
  logic mosi;
  logic miso;
  logic ss_n;
  modport port_end (input sck, input mosi, input ss_n, output miso);
  modport far_end (output sck, output mosi, output ss_n, input miso);
endinterface // spiovr_link_if

// ### src/spiovr_port.sv
/*
  SPI port, slave-facing link end, with the known overrun, counter and
  buffering faults, registers over APB and a level interrupt.
  Assumes link pins asynchronous to clk_sys_i; master mode mirrors the
  clock on miso path is out of scope, master uses internal shifting.
*/
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module spiovr_port (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Interrupt
  output logic irq_o,
  // Master mode pins
  output logic m_sck_o,
  output logic m_mosi_o,
  output logic m_ss_n_o,
  // Link
  spiovr_link_if.port_end link
);
  ////////////////////////////////////////////////////////////////////
  logic [31:0] ctrl_reg;
  logic [3:0] imsk_reg;
  logic [15:0] txd_reg, shtx_reg, shrx_reg, rxd_reg;
  logic txfull_reg, full_reg, ovr_reg, halt_reg;
  logic [3:0] bitcnt_reg;
  logic [2:0] sck_s_reg, ss_s_reg;
  logic [1:0] mosi_s_reg;
  logic miso_reg;
  logic [7:0] div_cnt_reg;
  logic busy_reg, m_sck_reg, m_ss_reg;
  logic en_q_reg;
  logic [3:0] len;
  logic en, mst, clock_phase_select;
  logic wr, rd, word_done, cap, shf, sck_r, sck_f, load_now;
  logic [15:0] rx_next;

  assign en = ctrl_reg[spiovr_pkg::CTRL_EN_BIT];
  assign mst = ctrl_reg[spiovr_pkg::CTRL_MST_BIT];
  assign clock_phase_select = ctrl_reg[spiovr_pkg::CTRL_CLOCK_PHASE_SELECT_BIT];
  assign len = ctrl_reg[spiovr_pkg::CTRL_LEN_LSB +: 4];
  assign wr = psel_i && penable_i && pwrite_i;
  assign rd = psel_i && penable_i && !pwrite_i;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only stage two onward is read
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      sck_s_reg <= 3'h0;
      ss_s_reg <= 3'h7;
      mosi_s_reg <= 2'h3;
    end else begin
      sck_s_reg <= {sck_s_reg[1:0], link.sck};
      ss_s_reg <= {ss_s_reg[1:0], link.ss_n};
      mosi_s_reg <= {mosi_s_reg[0], link.mosi};
    end
  end
  assign sck_r = !mst && !ss_s_reg[1] && sck_s_reg[1] && !sck_s_reg[2];
  assign sck_f = !mst && !ss_s_reg[1] && !sck_s_reg[1] && sck_s_reg[2];

  ////////////////////////////////////////////////////////////////////
  // Master clock generator; idle input reads as ones
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      div_cnt_reg <= 8'h00;
      m_sck_reg <= 1'b0;
      m_ss_reg <= 1'b1;
      busy_reg <= 1'b0;
    end else if (!en || !mst) begin
      div_cnt_reg <= 8'h00;
      m_sck_reg <= 1'b0;
      m_ss_reg <= 1'b1;
      busy_reg <= 1'b0;
    end else if (!busy_reg) begin
      if (txfull_reg && !halt_reg) begin
        busy_reg <= 1'b1;
        m_ss_reg <= 1'b0;
      end
    end else if (div_cnt_reg >= ctrl_reg[spiovr_pkg::CTRL_DIV_LSB +: 8]) begin
      div_cnt_reg <= 8'h00;
      m_sck_reg <= !m_sck_reg;
      // Counter wraps at the last capture, so the falling tick sees zero
      if (m_sck_reg && bitcnt_reg == 4'h0) begin
        busy_reg <= 1'b0;
        m_ss_reg <= 1'b1;
      end
    end else begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
    end
  end
  logic m_tick;
  assign m_tick = mst && busy_reg && (div_cnt_reg >= ctrl_reg[spiovr_pkg::CTRL_DIV_LSB +: 8]);
  // Master samples on rising, shifts on falling; input idles high
  assign cap = (m_tick && !m_sck_reg) || (clock_phase_select ? sck_f : sck_r);
  assign shf = (m_tick && m_sck_reg) || (clock_phase_select ? sck_r : sck_f);
  assign word_done = (bitcnt_reg == len);

  ////////////////////////////////////////////////////////////////////
  // Bit counter: slave never clears it on select, fault kept
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      bitcnt_reg <= 4'h0;
    end else if (mst && !busy_reg) begin
      bitcnt_reg <= 4'h0;
    end else if (cap) begin
      bitcnt_reg <= word_done ? 4'h0 : bitcnt_reg + 4'h1;
    end
  end

  // Receive shifter never cleared: residue after overrun
  assign rx_next = {shrx_reg[14:0], mst ? 1'b1 : mosi_s_reg[1]};
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      shrx_reg <= 16'h0000;
    end else if (cap) begin
      shrx_reg <= rx_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Receive register, full and overrun; set wins over clear
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      rxd_reg <= 16'h0000;
      full_reg <= 1'b0;
      ovr_reg <= 1'b0;
      halt_reg <= 1'b0;
    end else begin
      if (cap && word_done) begin
        if (!full_reg) begin
          rxd_reg <= rx_next;
        end
        full_reg <= 1'b1;
        if (full_reg) begin
          ovr_reg <= 1'b1;
          if (mst && len != 4'hf) begin
            halt_reg <= 1'b1;
          end
        end
      end else begin
        if (rd && hit(paddr_i, spiovr_pkg::RXD_OFS)) begin
          full_reg <= 1'b0;
        end
        if (wr && hit(paddr_i, spiovr_pkg::STAT_OFS) && pwdata_i[spiovr_pkg::ST_OVR_BIT]) begin
          ovr_reg <= 1'b0;
        end
      end
      // Only an enable cycle releases the halt
      if (!en) begin
        halt_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Transmit buffer and shifter, double-load fault kept
  // Disabled master keeps its held word until enable returns
  assign load_now = txfull_reg && (mst ? (en && !busy_reg && !halt_reg) :
    (!clock_phase_select ? 1'b0 : cap && word_done));
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      txd_reg <= 16'h0000;
      txfull_reg <= 1'b0;
      shtx_reg <= 16'hffff;
      en_q_reg <= 1'b0;
    end else begin
      en_q_reg <= en;
      if (wr && hit(paddr_i, spiovr_pkg::TXD_OFS)) begin
        txd_reg <= pwdata_i[15:0];
        txfull_reg <= 1'b1;
      end else if (load_now) begin
        txfull_reg <= 1'b0;
      end
      if (load_now) begin
        shtx_reg <= txd_reg << (4'hf - len);
      end else if (en && !en_q_reg && !mst && txfull_reg) begin
        shtx_reg <= txd_reg << (4'hf - len);
      end else if (shf) begin
        shtx_reg <= {shtx_reg[14:0], 1'b1};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      ctrl_reg <= spiovr_pkg::CTRL_RST;
      imsk_reg <= spiovr_pkg::EVT_RST;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
      pready_o <= 1'b0;
    end else begin
      pslverr_o <= 1'b0;
      pready_o <= psel_i && !penable_i;
      if (wr && hit(paddr_i, spiovr_pkg::CTRL_OFS)) begin
        ctrl_reg <= pwdata_i;
      end
      if (wr && hit(paddr_i, spiovr_pkg::IMSK_OFS)) begin
        imsk_reg <= pwdata_i[3:0];
      end
      if (psel_i && !penable_i) begin
        pslverr_o <= !(hit(paddr_i, spiovr_pkg::CTRL_OFS) || hit(paddr_i, spiovr_pkg::STAT_OFS) ||
          hit(paddr_i, spiovr_pkg::TXD_OFS) || hit(paddr_i, spiovr_pkg::RXD_OFS) ||
          hit(paddr_i, spiovr_pkg::IMSK_OFS));
        unique case (paddr_i)
          spiovr_pkg::CTRL_OFS: prdata_o <= ctrl_reg;
          spiovr_pkg::STAT_OFS: prdata_o <= {28'h0, halt_reg, !txfull_reg, ovr_reg, full_reg};
          spiovr_pkg::TXD_OFS: prdata_o <= {16'h0, txd_reg};
          spiovr_pkg::RXD_OFS: prdata_o <= {16'h0, rxd_reg};
          spiovr_pkg::IMSK_OFS: prdata_o <= {28'h0, imsk_reg};
          default: prdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Outputs from flops
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      irq_o <= 1'b0;
      miso_reg <= 1'b1;
    end else begin
      irq_o <= |(imsk_reg & {halt_reg, !txfull_reg, ovr_reg, full_reg});
      miso_reg <= shtx_reg[15];
    end
  end
  assign link.miso = miso_reg;
  assign m_sck_o = m_sck_reg;
  assign m_ss_n_o = m_ss_reg;
  assign m_mosi_o = miso_reg;
endmodule // spiovr_port

// ### src/spiovr_master.sv
/*
  Far-end SPI master: sends one word per command, exact edge count.
  Assumes a phase-0 port on the link; runs on clk_sys_i.
*/
`timescale 1ns/100ps
module spiovr_master (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Command
  input wire logic start_i,
  input wire logic [15:0] word_i,
  input wire logic [3:0] len_i,
  output logic busy_o,
  output logic done_o,
  // Link
  spiovr_link_if.far_end link
);
  logic [15:0] sh_reg;
  // One bit wider than a word of edges, so sixteen bits do not wrap
  logic [5:0] edge_reg;
  logic [3:0] bits_reg;
  logic [7:0] half_reg;
  logic sck_reg, ss_reg;
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      sh_reg <= 16'h0000;
      bits_reg <= 4'h0;
      edge_reg <= 6'h00;
      half_reg <= 8'h00;
      sck_reg <= 1'b0;
      ss_reg <= 1'b1;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (!busy_o) begin
        if (start_i) begin
          sh_reg <= word_i << (4'hf - len_i);
          bits_reg <= len_i;
          edge_reg <= 6'h00;
          half_reg <= 8'h00;
          ss_reg <= 1'b0;
          busy_o <= 1'b1;
        end
      end else if (half_reg < 8'(4 * spiovr_pkg::SCK_HALF_MIN_CYC)) begin
        half_reg <= half_reg + 8'h01;
      end else begin
        half_reg <= 8'h00;
        // Exactly two edges per bit, no surplus clocks
        if (edge_reg == {1'b0, bits_reg, 1'b1} + 6'h01) begin
          ss_reg <= 1'b1;
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          sck_reg <= !sck_reg;
          edge_reg <= edge_reg + 6'h01;
          if (sck_reg) begin
            sh_reg <= {sh_reg[14:0], 1'b0};
          end
        end
      end
    end
  end
  assign link.sck = sck_reg;
  assign link.ss_n = ss_reg;
  assign link.mosi = sh_reg[15];
endmodule // spiovr_master

// ### verif/spiovr_link_assertions.sv
/*
  Link frame checks on the shared serial link.
  Assumes instantiation beside the link interface, one clock domain.
*/
`timescale 1ns/100ps
module spiovr_link_chk (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Link
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic ss_n
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  logic sck_q_reg;
  logic [4:0] edge_cnt_reg;
  always_ff @(posedge clk_sys_i) begin
    sck_q_reg <= sck;
  end
  // Rising serial clock edges in this frame
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i || ss_n) edge_cnt_reg <= 5'h00;
    else if (sck && !sck_q_reg) edge_cnt_reg <= edge_cnt_reg + 5'h01;
  end
  sequence s_open; $fell(ss_n) && !sck; endsequence
  sequence s_close; $rose(ss_n) && !sck; endsequence
  property p_idle; ss_n |-> !sck; endproperty
  property p_open; $fell(ss_n) |-> s_open; endproperty
  property p_close; $rose(ss_n) |-> s_close; endproperty
  // Half period is 9 system clocks
  property p_half; $changed(sck) |=> $stable(sck)[*8]; endproperty
  property p_frame; s_open |-> ##[2:700] s_close; endproperty
  property p_count; $rose(ss_n) |-> edge_cnt_reg inside {[5'h01:5'h10]}; endproperty
  property p_gap; $rose(ss_n) |=> ss_n; endproperty
  property p_in_frame; $changed(sck) |-> !ss_n; endproperty
  property p_mosi; $changed(mosi) |-> $fell(sck) || $fell(ss_n); endproperty
  a_idle: assert property (p_idle) else $error("clock moves while deselected");
  a_open: assert property (p_open) else $error("frame opens with clock high");
  a_close: assert property (p_close) else $error("frame closes with clock high");
  a_half: assert property (p_half) else $error("serial half period too short");
  a_frame: assert property (p_frame) else $error("frame too long");
  a_count: assert property (p_count) else $error("edge count outside word length");
  a_gap: assert property (p_gap) else $error("no gap between frames");
  a_in_frame: assert property (p_in_frame) else $error("clock edge outside frame");
  a_mosi: assert property (p_mosi) else $error("data moves off the shift edge");
endmodule // spiovr_link_chk

// ### verif/spi_port_overrun_behaviour_tb.sv
/*
  Self-checking bench: port and far-end master joined by the link.
  Assumes APB zero-wait slave and registered read data.
*/
`timescale 1ns/100ps
module spi_port_overrun_behaviour_tb;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, chk = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic pready_o, pslverr_o, irq_o, busy_o, done_o;
  logic start_i = 1'b0;
  logic [15:0] word_i = 16'h0, w1, w2;
  logic [3:0] len_i = 4'h0;
  logic [32:0] eq[$], mq[$], me, mm;
  int num_errors = 0;
  int checks_done = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  spiovr_link_if link ();
  spiovr_port u_spiovr_port (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o),
    .m_sck_o(), .m_mosi_o(), .m_ss_n_o(), .link(link));
  spiovr_master u_spiovr_master (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .start_i(start_i),
    .word_i(word_i), .len_i(len_i), .busy_o(busy_o), .done_o(done_o), .link(link));
  spiovr_link_chk u_spiovr_link_chk (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .sck(link.sck),
    .mosi(link.mosi), .miso(link.miso), .ss_n(link.ss_n));
  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic fail();
    num_errors++;
    $display("ERROR %0t: wait ran out", $time);
    conclude();
  endtask
  // One APB transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e, input logic [32:0] m, input logic c);
    int n;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    chk <= c;
    if (c) begin
      eq.push_back(e);
      mq.push_back(m);
    end
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    n = 0;
    do begin @(posedge clk_sys_i); n++; end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) fail();
    rd = prdata_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    chk <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0, 33'h0, 1'b0);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
    apb(1'b0, a, 32'h0, e, m, 1'b1);
  endtask
  task automatic poll(input int b);
    int n;
    n = 0;
    do begin apb(1'b0, spiovr_pkg::STAT_OFS, 32'h0, 33'h0, 33'h0, 1'b0); n++; end
    while (rd[b] !== 1'b1 && n < 3000);
    if (n >= 3000) fail();
  endtask
  task automatic send(input logic [15:0] w);
    int n;
    start_i <= 1'b1;
    word_i <= w;
    len_i <= 4'hf;
    @(posedge clk_sys_i);
    start_i <= 1'b0;
    n = 0;
    do begin @(posedge clk_sys_i); n++; end while (done_o !== 1'b1 && n < 2000);
    if (n >= 2000) fail();
    @(posedge clk_sys_i);
  endtask
  // Compares each checked read as it completes against the oldest note
  always @(posedge clk_sys_i) begin
    if (psel_i && penable_i && pready_o === 1'b1 && chk && eq.size() > 0) begin
      me = eq.pop_front();
      mm = mq.pop_front();
      check({pslverr_o, prdata_o} & mm, me);
    end
  end
  //////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hd94b7962));
    w1 = 16'($urandom);
    w2 = 16'($urandom);
    repeat (8) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    @(posedge clk_sys_i);
    rdc(spiovr_pkg::CTRL_OFS, {1'b0, spiovr_pkg::CTRL_RST}, 33'h1ffffffff);
    rdc(spiovr_pkg::IMSK_OFS, 33'h0, 33'h1ffffffff);
    rdc(8'h14, 33'h100000000, 33'h1ffffffff);
    rdc(spiovr_pkg::STAT_OFS, 33'h0, 33'h0000000b);
    // Slave, phase 0, sixteen bits; far master shifts on falling edges
    wr(spiovr_pkg::CTRL_OFS, 32'h0000_0ff1);
    send(w1);
    rdc(spiovr_pkg::STAT_OFS, 33'h1, 33'h3);
    wr(spiovr_pkg::CTRL_OFS, 32'h0000_0ff0);
    wr(spiovr_pkg::CTRL_OFS, 32'h0000_0ff1);
    check(33'(irq_o), 33'h0);
    wr(spiovr_pkg::IMSK_OFS, 32'h1);
    @(posedge clk_sys_i);
    check(33'(irq_o), 33'h1);
    rdc(spiovr_pkg::RXD_OFS, {17'h0, w1}, 33'h0000ffff);
    send(w2);
    send(~w2);
    rdc(spiovr_pkg::STAT_OFS, 33'h3, 33'h3);
    wr(spiovr_pkg::STAT_OFS, 32'h2);
    rdc(spiovr_pkg::RXD_OFS, {17'h0, w2}, 33'h0000ffff);
    rdc(spiovr_pkg::STAT_OFS, 33'h0, 33'h3);
    @(posedge clk_sys_i);
    check(33'(irq_o), 33'h0);
    // Master, eight bits, receive read once then left; upper bits are slave residue
    wr(spiovr_pkg::CTRL_OFS, 32'h0000_0f73);
    wr(spiovr_pkg::TXD_OFS, {16'h0, w1});
    poll(spiovr_pkg::ST_FULL_BIT);
    rdc(spiovr_pkg::RXD_OFS, {17'h0, ~w2[7:0], 8'hff}, 33'h0000ffff);
    wr(spiovr_pkg::TXD_OFS, {16'h0, w2});
    poll(spiovr_pkg::ST_TXE_BIT);
    wr(spiovr_pkg::TXD_OFS, {16'h0, w2});
    poll(spiovr_pkg::ST_HALT_BIT);
    rdc(spiovr_pkg::STAT_OFS, 33'ha, 33'ha);
    // A held word must stay held after the overrun clear
    wr(spiovr_pkg::TXD_OFS, {16'h0, w1});
    wr(spiovr_pkg::STAT_OFS, 32'h2);
    rdc(spiovr_pkg::STAT_OFS, 33'h8, 33'he);
    wr(spiovr_pkg::CTRL_OFS, 32'h0000_0f72);
    rdc(spiovr_pkg::RXD_OFS, {17'h0, 16'hffff}, 33'h0000ffff);
    wr(spiovr_pkg::CTRL_OFS, 32'h0000_0ff3);
    rdc(spiovr_pkg::STAT_OFS, 33'h4, 33'hc);
    // Master, sixteen bits: overrun without halt
    wr(spiovr_pkg::TXD_OFS, {16'h0, w1});
    for (int i = 0; i < 2; i++) begin
      poll(spiovr_pkg::ST_TXE_BIT);
      wr(spiovr_pkg::TXD_OFS, {16'h0, w2});
    end
    poll(spiovr_pkg::ST_OVR_BIT);
    rdc(spiovr_pkg::STAT_OFS, 33'h2, 33'ha);
    conclude();
  end
endmodule // spi_port_overrun_behaviour_tb
